// ===== include/brf_pkg.sv
/*
 * brf_pkg: shared constants for the banked register file block.
 * assumes: used by rtl/brf_core.sv and the bench, never imported.
 */
package brf_pkg;
    // ****************************************
    // apb register map (own offsets)
    // ****************************************
    localparam logic [11:0] GPR_BASE = 12'h000; // 16 visible general registers, word each
    localparam logic [11:0] CURRENT_STATUS_WORD_OFF = 12'h040; // current_status_word
    localparam logic [11:0] SAVED_STATUS_WORD_OFF = 12'h044; // saved_status_word of current mode
    localparam logic [11:0] CFG_OFF = 12'h048; // configuration inputs, read only
    localparam logic [11:0] EXC_OFF = 12'h04C; // exception entry command, write only
    localparam logic [11:0] BL_OFF = 12'h050; // branch-with-link command
    localparam logic [11:0] ALU_OFF = 12'h054; // flag update from alu
    localparam logic [11:0] LANE_OFF = 12'h058; // byte lane steering: write byte address
    localparam logic [11:0] IRQG_OFF = 12'h05C; // interrupt gating status
    localparam logic [11:0] ABT_OFF = 12'h060; // data abort policy status
    // ****************************************
    // status word layout
    // ****************************************
    localparam int N_BIT = 31;
    localparam int Z_BIT = 30;
    localparam int C_BIT = 29;
    localparam int V_BIT = 28;
    localparam int I_BIT = 7;
    localparam int F_BIT = 6;
    localparam logic [31:0] CTRL_MASK = 32'h0FFF_FFFF; // low 28 bits are control
    localparam logic [31:0] FLAG_MASK = 32'hF000_0000;
    // ****************************************
    // modes and reset values
    // ****************************************
    typedef enum logic [4:0] {
        MODE_USR = 5'h10,
        MODE_FIQ = 5'h11,
        MODE_IRQ = 5'h12,
        MODE_SVC = 5'h13,
        MODE_ABT = 5'h17,
        MODE_UND = 5'h1B
    } brf_mode_t;
    localparam logic [31:0] CURRENT_STATUS_WORD_RESET = 32'h0000_00D3; // svc, i and f set
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
endpackage : brf_pkg

// ===== rtl/brf_core.sv
/*
 * brf_core: banked general registers, current and saved status words,
 * byte lane steering and configuration inputs, all behind an apb slave.
 * assumes: one clock mclk at 100 MHz, arst_n asynchronous active low,
 * configuration and interrupt pins asynchronous to mclk.
 */
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
module brf_core (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic byte_order_select,
    input wire logic abort_style_select,
    input wire logic wide_fetch_space_select,
    input wire logic wide_data_space_select,
    input wire logic irq_req_n,
    input wire logic fiq_req_n,
    output logic [4:0] mode_out,
    output logic irq_take,
    output logic fiq_take
);
    // ****************************************
    // storage
    // ****************************************
    // pc lives in entry 15 and is shared by every mode
    logic [31:0] gpr_reg [0:30]; // 31 physical general registers (incl. pc)
    logic [31:0] current_status_word_reg; // current status word
    logic [31:0] saved_status_word_reg [0:4]; // five saved words: fiq irq svc abt und
    logic [3:0] cfg_s1_reg; // config first sync stage
    logic [3:0] cfg_s2_reg; // config synced
    logic [1:0] int_s1_reg; // interrupt first sync stage
    logic [1:0] int_s2_reg; // interrupt synced, active low
    // bus response registers
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    // gated interrupt levels
    logic irq_take_reg;
    logic fiq_take_reg;
    // last byte lane steering result, readable back
    logic [31:0] lane_reg; // byte lane result

    // ****************************************
    // bus decode
    // ****************************************
    // an access is taken in its first access cycle; the pready pulse
    // masks the second cycle, so a request held for two access cycles is not applied twice
    wire logic acc = psel && penable && !pready_reg; // access phase, first cycle
    wire logic wr = acc && pwrite;
    // upper address bits of the general register window
    localparam logic [5:0] GPR_BASE_HI = brf_pkg::GPR_BASE[11:6];
    // word aligned hit in the general window; a byte offset is refused
    wire logic is_gpr = (paddr[11:6] == GPR_BASE_HI) && (paddr[1:0] == 2'h0);
    wire logic [3:0] ridx = paddr[5:2];
    // live mode field drives every bank choice below except on exception entry, whose link and saved word follow the target mode
    wire logic [4:0] mode = current_status_word_reg[4:0];
    wire logic priv = (mode != brf_pkg::MODE_USR);
    // synced configuration bits, one per pin
    wire logic big_end = cfg_s2_reg[0];
    wire logic late_abt = cfg_s2_reg[1];

    // saved word slot for a mode, 3'h7 for user or illegal
    // the slot doubles as the privilege test: no slot, no saved word
    function automatic logic [2:0] saved_status_word_slot(input logic [4:0] m);
        unique case (m)
            brf_pkg::MODE_FIQ: saved_status_word_slot = 3'h0;
            brf_pkg::MODE_IRQ: saved_status_word_slot = 3'h1;
            brf_pkg::MODE_SVC: saved_status_word_slot = 3'h2;
            brf_pkg::MODE_ABT: saved_status_word_slot = 3'h3;
            brf_pkg::MODE_UND: saved_status_word_slot = 3'h4;
            default: saved_status_word_slot = 3'h7;
        endcase
    endfunction : saved_status_word_slot

    // physical index of visible register r in mode m
    // 0..15 user/shared, 16..22 fiq r8-r14, 23..30 r13/r14 of irq svc abt und
    function automatic logic [4:0] phys(input logic [4:0] m, input logic [3:0] r);
        logic [2:0] s;
        s = saved_status_word_slot(m);
        phys = {1'b0, r};
        if (m == brf_pkg::MODE_FIQ && r >= 4'h8 && r <= 4'hE) begin
            // fast mode swaps in its seven private registers
            phys = 5'(r) + 5'h08;
        end else if (s != 3'h7 && s != 3'h0 && (r == 4'hD || r == 4'hE)) begin
            // two entries per mode from 23 up; r[1] picks the link over the stack
            phys = 5'h17 + {1'b0, 3'(s - 3'h1), 1'b0} + {4'h0, r[1]};
        end
    endfunction : phys

    wire logic [2:0] cur_slot = saved_status_word_slot(mode);
    wire logic [4:0] sel = phys(mode, ridx); // bank follows live mode field
    // a pc read always shows its two low bits as zero
    wire logic [31:0] gpr_rd = (ridx == 4'hF) ? {gpr_reg[15][31:2], 2'h0} : gpr_reg[sel];
    // user mode has no saved word, so it reads as zero
    wire logic [31:0] saved_status_word_rd = (cur_slot == 3'h7) ? 32'h0 : saved_status_word_reg[cur_slot];
    // single word registers above the general window
    wire logic hit_current_status_word = (paddr == brf_pkg::CURRENT_STATUS_WORD_OFF);
    wire logic hit_saved_status_word = (paddr == brf_pkg::SAVED_STATUS_WORD_OFF);
    wire logic hit_cfg = (paddr == brf_pkg::CFG_OFF);
    wire logic hit_exc = (paddr == brf_pkg::EXC_OFF);
    wire logic hit_bl = (paddr == brf_pkg::BL_OFF);
    wire logic hit_alu = (paddr == brf_pkg::ALU_OFF);
    wire logic hit_lane = (paddr == brf_pkg::LANE_OFF);
    wire logic hit_irqg = (paddr == brf_pkg::IRQG_OFF);
    wire logic hit_abt = (paddr == brf_pkg::ABT_OFF);
    wire logic mapped = is_gpr | hit_current_status_word | hit_saved_status_word | hit_cfg | hit_exc | hit_bl | hit_alu | hit_lane
        | hit_irqg | hit_abt;

    // exception entry: pwdata[4:0] is target mode, must be a privileged code
    wire logic [4:0] exc_mode = pwdata[4:0];
    wire logic [2:0] exc_slot = saved_status_word_slot(exc_mode);
    wire logic exc_ok = wr && hit_exc && exc_slot != 3'h7;
    // entry loads the target mode and sets the irq mask, and the fiq mask too on fast entry; the other
    // control bits and the flags ride through unchanged
    wire logic [31:0] exc_current_status_word = {current_status_word_reg[31:8], 1'b1, (exc_mode == brf_pkg::MODE_FIQ) | current_status_word_reg[6],
        current_status_word_reg[5], exc_mode};
    // software current_status_word write: flags always, control only when privileged
    // a user write keeps the control bits, so a task cannot raise its privilege
    // a privileged write carrying a code outside the six is dropped whole
    wire logic [31:0] sw_current_status_word = priv ? pwdata : ((pwdata & brf_pkg::FLAG_MASK) | (current_status_word_reg & brf_pkg::CTRL_MASK));
    wire logic legal_mode = (saved_status_word_slot(pwdata[4:0]) != 3'h7) || (pwdata[4:0] == brf_pkg::MODE_USR);
    wire logic current_status_word_wr_ok = wr && hit_current_status_word && (!priv || legal_mode);
    // alu flag update: pwdata[31:28] = n z c v
    // update priority: exception entry, then software write, then alu flags
    wire logic [31:0] alu_current_status_word = (pwdata & brf_pkg::FLAG_MASK) | (current_status_word_reg & brf_pkg::CTRL_MASK);
    wire logic [31:0] current_status_word_next = exc_ok ? exc_current_status_word : (current_status_word_wr_ok ? sw_current_status_word : ((wr && hit_alu) ? alu_current_status_word : current_status_word_reg));

    // byte lane steering: pwdata[1:0] byte address, pwdata[15:8] byte
    // little endian puts byte 0 on lane 7:0, big endian on lane 31:24
    wire logic [1:0] lane = big_end ? (2'h3 - pwdata[1:0]) : pwdata[1:0];
    wire logic [31:0] lane_next = {24'h0, pwdata[15:8]} << {lane, 3'h0};

    // pending gated interrupts
    // a set mask bit holds its take output low from the next edge on
    wire logic irq_next = !int_s2_reg[0] && !current_status_word_reg[brf_pkg::I_BIT];
    wire logic fiq_next = !int_s2_reg[1] && !current_status_word_reg[brf_pkg::F_BIT];

    // read mux
    // unmapped offsets read zero and raise pslverr instead
    wire logic [31:0] rd_mux = is_gpr ? gpr_rd :
        hit_current_status_word ? current_status_word_reg :
        hit_saved_status_word ? saved_status_word_rd :
        hit_cfg ? {28'h0, cfg_s2_reg} :
        hit_lane ? lane_reg :
        hit_irqg ? {30'h0, fiq_take_reg, irq_take_reg} :
        hit_abt ? {31'h0, late_abt} : 32'h0; // bit0 = single transfer writes back base

    // ****************************************
    // synchronisers
    // ****************************************
    // config pins resampled every cycle, so changes apply two edges later
    // two flops per pin keep metastability out of the decode; the interrupt
    // stages reset to the idle high level so no false request follows reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_s1_reg <= 4'h0;
            cfg_s2_reg <= 4'h0;
            int_s1_reg <= 2'h3;
            int_s2_reg <= 2'h3;
        end else begin
            cfg_s1_reg <= {wide_data_space_select, wide_fetch_space_select, abort_style_select, byte_order_select};
            cfg_s2_reg <= cfg_s1_reg;
            int_s1_reg <= {fiq_req_n, irq_req_n};
            int_s2_reg <= int_s1_reg;
        end
    end

    // ****************************************
    // apb response, one wait state per access
    // ****************************************
    // prdata stands only with the pready pulse and reads zero otherwise,
    // so a stale value never looks like an answer
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= acc;
            pslverr_reg <= acc && !mapped;
            prdata_reg <= (acc && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // ****************************************
    // status words
    // ****************************************
    // one update per edge: the priority chain above picks the source;
    // the take outputs follow the synced pins, gated by the mask bits
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            current_status_word_reg <= brf_pkg::CURRENT_STATUS_WORD_RESET;
            lane_reg <= 32'h0;
            irq_take_reg <= 1'b0;
            fiq_take_reg <= 1'b0;
        end else begin
            current_status_word_reg <= current_status_word_next;
            irq_take_reg <= irq_next;
            fiq_take_reg <= fiq_next;
            if (wr && hit_lane) begin
                lane_reg <= lane_next;
            end
        end
    end

    // saved words: exception copies current_status_word, privileged software may write
    // one process per slot; a user mode write finds no slot and is dropped
    generate
        for (genvar k = 0; k < 5; k++) begin : g_saved_status_word
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    saved_status_word_reg[k] <= 32'h0;
                end else if (exc_ok && exc_slot == 3'(k)) begin
                    saved_status_word_reg[k] <= current_status_word_reg;
                end else if (wr && hit_saved_status_word && cur_slot == 3'(k)) begin
                    saved_status_word_reg[k] <= pwdata;
                end
            end
        end
    endgenerate

    // ****************************************
    // general registers
    // ****************************************
    // link target for exception entry in new bank
    wire logic [4:0] exc_lr = phys(exc_mode, 4'hE);
    // branch link writes the link of the mode in force
    wire logic [4:0] bl_lr = phys(mode, 4'hE);
    // priority per entry: exception link, branch link, then bus write;
    // the pc entry keeps its low bits clear on every bus write
    generate
        for (genvar j = 0; j < 31; j++) begin : g_gpr
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    gpr_reg[j] <= brf_pkg::PC_RESET;
                end else if (exc_ok && exc_lr == 5'(j)) begin
                    gpr_reg[j] <= gpr_reg[15]; // return address into new link register
                end else if (wr && hit_bl && bl_lr == 5'(j)) begin
                    gpr_reg[j] <= {gpr_reg[15][31:2], 2'h0};
                end else if (wr && is_gpr && sel == 5'(j)) begin
                    gpr_reg[j] <= (j == 15) ? {pwdata[31:2], 2'h0} : pwdata;
                end
            end
        end
    endgenerate

    // ****************************************
    // outputs
    // ****************************************
    // every output is a register copy, no logic after the flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mode_out = current_status_word_reg[4:0];
    assign irq_take = irq_take_reg;
    assign fiq_take = fiq_take_reg;

    // ****************************************
    // checks
    // ****************************************
    // behaviour of the banks, the status words, the interrupt gating and the config sync
    a_pc_low_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        pready && !pwrite && $past(paddr) == 12'h03C |-> prdata[1:0] == 2'h0)
        else $error("pc read shows nonzero low bits");
    a_user_no_ctrl: assert property (@(posedge mclk) disable iff (!arst_n)
        (!priv && !exc_ok) |=> current_status_word_reg[27:0] == $past(current_status_word_reg[27:0]))
        else $error("user mode altered control bits");
    a_exc_saves: assert property (@(posedge mclk) disable iff (!arst_n)
        exc_ok |=> saved_status_word_reg[$past(exc_slot)] == $past(current_status_word_reg) && mode_out == $past(exc_mode))
        else $error("exception entry did not save status");
    a_irq_masked: assert property (@(posedge mclk) disable iff (!arst_n)
        current_status_word_reg[brf_pkg::I_BIT] |=> !irq_take)
        else $error("irq passed while masked");
    a_fiq_masked: assert property (@(posedge mclk) disable iff (!arst_n)
        current_status_word_reg[brf_pkg::F_BIT] |=> !fiq_take)
        else $error("fiq passed while masked");
    a_user_no_saved_status_word: assert property (@(posedge mclk) disable iff (!arst_n)
        acc && !pwrite && hit_saved_status_word && !priv |=> prdata == 32'h0)
        else $error("saved word visible in user mode");
    a_fiq_bank: assert property (@(posedge mclk) disable iff (!arst_n)
        mode == brf_pkg::MODE_FIQ && ridx == 4'h8 |-> sel == 5'h10)
        else $error("fast bank not selected");
    a_cfg_live: assert property (@(posedge mclk) disable iff (!arst_n)
        ##2 cfg_s2_reg[0] == $past(byte_order_select, 2))
        else $error("config input not followed");

    // ****************************************
    // command checks: link copy, byte lanes, mode codes
    // ****************************************
    // branch link request taken on the bus
    sequence s_bl_cmd;
        wr && hit_bl;
    endsequence
    // byte lane write for byte address zero
    sequence s_lane0_cmd;
        wr && hit_lane && pwdata[1:0] == 2'h0;
    endsequence
    // exception entry with a privileged target mode
    sequence s_exc_cmd;
        exc_ok;
    endsequence
    a_bl_link: assert property (@(posedge mclk) disable iff (!arst_n)
        s_bl_cmd |=> gpr_reg[$past(bl_lr)] == {$past(gpr_reg[15][31:2]), 2'h0})
        else $error("branch link did not copy pc");
    a_lane_little: assert property (@(posedge mclk) disable iff (!arst_n)
        s_lane0_cmd ##0 !big_end |=> lane_reg == {24'h0, $past(pwdata[15:8])})
        else $error("little endian byte 0 not on low lane");
    a_lane_big: assert property (@(posedge mclk) disable iff (!arst_n)
        s_lane0_cmd ##0 big_end |=> lane_reg == {$past(pwdata[15:8]), 24'h0})
        else $error("big endian byte 0 not on high lane");
    a_exc_sets_i: assert property (@(posedge mclk) disable iff (!arst_n)
        s_exc_cmd |=> current_status_word_reg[brf_pkg::I_BIT] && current_status_word_reg[31:28] == $past(current_status_word_reg[31:28]))
        else $error("exception entry left irq unmasked");
    a_mode_known: assert property (@(posedge mclk) disable iff (!arst_n)
        !priv || cur_slot != 3'h7)
        else $error("mode field holds an unlisted code");
    a_pc_aligned: assert property (@(posedge mclk) disable iff (!arst_n)
        gpr_reg[15][1:0] == 2'h0)
        else $error("program counter lost word alignment");
endmodule : brf_core

// ===== verif/brf_testbench.sv
/*
 * testbench: self-checking bench for brf_core, with scenario tasks driving apb and the pins.
 * assumes: brf_pkg compiled first; one wait state per apb access; pins synced within a few mclk.
 */
`timescale 1ns/1ns
module testbench;
    // ****************************************
    // signals and design instance
    // ****************************************
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic bo, ab, wf, wd, irq_n, fiq_n, irq_take, fiq_take, serr;
    logic [4:0] mode_out;
    int err_total = 0;
    int comparisons = 0;
    brf_core uut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .byte_order_select(bo), .abort_style_select(ab), .wide_fetch_space_select(wf),
        .wide_data_space_select(wd), .irq_req_n(irq_n), .fiq_req_n(fiq_n), .mode_out(mode_out),
        .irq_take(irq_take), .fiq_take(fiq_take));
    // free running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        // a missing answer counts as a mismatch and ends the run
        if (n == 50) begin
            err_total++;
            $display("Error at %0t: no pready for offset %h", $time, a);
            final_report();
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, e);
    endtask : rd
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // ****************************************
    // scenarios
    // ****************************************
    // reset state: supervisor mode, both masks set
    task automatic t_reset();
        chk({27'h0, mode_out}, 32'h0000_0013);
        rd(brf_pkg::CURRENT_STATUS_WORD_OFF, brf_pkg::CURRENT_STATUS_WORD_RESET);
    endtask : t_reset
    // exception chain through every privileged mode, checking saved word and link copy
    task automatic t_exc();
        logic [4:0] m[5];
        logic [31:0] prev, nxt;
        m = '{5'h12, 5'h11, 5'h17, 5'h1B, 5'h13};
        wr(12'h03C, 32'h0000_0103);
        rd(12'h03C, 32'h0000_0100);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_0013);
        prev = 32'h0000_0013;
        foreach (m[i]) begin
            nxt = (prev & 32'hFFFF_FFE0) | {27'h0, m[i]} | 32'h80 | ((m[i] == 5'h11) ? 32'h40 : 32'h0);
            wr(brf_pkg::EXC_OFF, {27'h0, m[i]});
            chk({27'h0, mode_out}, {27'h0, m[i]});
            rd(brf_pkg::CURRENT_STATUS_WORD_OFF, nxt);
            rd(brf_pkg::SAVED_STATUS_WORD_OFF, prev);
            rd(12'h038, 32'h0000_0100);
            prev = nxt;
        end
        wr(12'h038, 32'h0000_0055);
        wr(brf_pkg::BL_OFF, 32'h0);
        rd(12'h038, 32'h0000_0100);
    endtask : t_exc
    // bank selection follows the mode field at once
    task automatic t_bank();
        wr(12'h000, 32'h0000_000A);
        wr(12'h020, 32'h0000_0008);
        wr(12'h034, 32'h0000_000D);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_00D1);
        rd(12'h020, 32'h0000_0000);
        rd(12'h000, 32'h0000_000A);
        wr(12'h020, 32'h0000_0088);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_00D2);
        rd(12'h020, 32'h0000_0008);
        rd(12'h034, 32'h0000_0000);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_00D3);
        rd(12'h034, 32'h0000_000D);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_00D5);
        rd(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_00D3);
        wr(brf_pkg::EXC_OFF, 32'h0000_0010);
        chk({27'h0, mode_out}, 32'h0000_0013);
    endtask : t_bank
    // user mode: no saved word, control bits locked, flags still writable
    task automatic t_user();
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_00D0);
        chk({27'h0, mode_out}, 32'h0000_0010);
        rd(brf_pkg::SAVED_STATUS_WORD_OFF, 32'h0000_0000);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'hF000_00D3);
        rd(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'hF000_00D0);
        wr(brf_pkg::ALU_OFF, 32'h5000_0000);
        rd(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h5000_00D0);
        wr(brf_pkg::EXC_OFF, 32'h0000_0013);
        rd(brf_pkg::SAVED_STATUS_WORD_OFF, 32'h5000_00D0);
    endtask : t_user
    // interrupt gating by the two mask bits
    task automatic t_gate();
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_00D3);
        irq_n <= 1'b0;
        fiq_n <= 1'b0;
        repeat (6) @(posedge mclk);
        chk({30'h0, fiq_take, irq_take}, 32'h0000_0000);
        rd(brf_pkg::IRQG_OFF, 32'h0000_0000);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_0013);
        repeat (6) @(posedge mclk);
        chk({30'h0, fiq_take, irq_take}, 32'h0000_0003);
        rd(brf_pkg::IRQG_OFF, 32'h0000_0003);
        wr(brf_pkg::CURRENT_STATUS_WORD_OFF, 32'h0000_0093);
        repeat (6) @(posedge mclk);
        chk({30'h0, fiq_take, irq_take}, 32'h0000_0002);
        rd(brf_pkg::IRQG_OFF, 32'h0000_0002);
        irq_n <= 1'b1;
        fiq_n <= 1'b1;
    endtask : t_gate
    // live configuration pins, byte lanes in both orders, unmapped access
    task automatic t_cfg();
        for (int o = 0; o < 2; o++) begin
            @(posedge mclk);
            bo <= o[0];
            ab <= ~o[0];
            wf <= o[0];
            wd <= ~o[0];
            repeat (4) @(posedge mclk);
            rd(brf_pkg::CFG_OFF, {28'h0, ~o[0], o[0], ~o[0], o[0]});
            rd(brf_pkg::ABT_OFF, {31'h0, ~o[0]});
            for (int a = 0; a < 4; a++) begin
                wr(brf_pkg::LANE_OFF, {16'h0, 8'hA5, 6'h0, a[1:0]});
                rd(brf_pkg::LANE_OFF, 32'h0000_00A5 << (8 * (o ? 3 - a : a)));
            end
        end
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, serr}, 32'h0000_0001);
        apb(1'b0, 12'h002, 32'h0);
        chk({31'h0, serr}, 32'h0000_0001);
    endtask : t_cfg
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        bo = 1'b0;
        ab = 1'b0;
        wf = 1'b1;
        wd = 1'b1;
        irq_n = 1'b1;
        fiq_n = 1'b1;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_exc();
        t_bank();
        t_user();
        t_gate();
        t_cfg();
        final_report();
    end
    // cut a hang short well beyond the expected run length
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule : testbench
